// *** ccpu_top.v ***
// capture/compare/pwm unit with its timers, flag registers and shared port pin
// Functional notes
// [RQ1] compare mode matches 16-bit compare value against 16-bit timer1 count
// [RQ2] on match pin goes high, low or stays, per mode bits 3:0
// [RQ3] every compare match sets the unit interrupt flag in that cycle
// [RQ4] software clears direction bit 2 to make the pin an output
// [RQ5] writing zero to control forces the unit output latch low
// [RQ6] software runs timer1 synchronously while compare is used
// [RQ7] software interrupt mode leaves the pin alone, raises only the flag
// [RQ8] special event mode resets timer1 on match, giving a period
// [RQ9] special event also starts a conversion when converter enabled
// [RQ10] special event reset of timer1 never sets timer1 overflow flag
// [RQ11] pwm mode drives a waveform of up to 10-bit duty
// [RQ12] period is (period+1) times 4 clocks times timer2 prescale
// [RQ13] after period match clear timer2, set pin unless 0%, load shadow
// [RQ14] duty is high bits register over control bits 5:4
// [RQ15] high time is duty times clock times prescale
// [RQ16] duty writes take effect at next period; shadow read-only in pwm
// [RQ17] shadow plus 2-bit latch double-buffer the duty
// [RQ18] pin clears when buffered duty equals extended timer2 count
// [RQ19] duty beyond period keeps the pin high all period
// [RQ20] mode 0000 off, 01xx capture, 10xx compare, 11xx pwm
// [RQ21] active unit: port reads 0 as input, latch as output
// [RQ22] capture events come from pin, or from the pin readback as output
// [RQ23] compare codes: set, clear, software interrupt, special event
`timescale 1ns/10ps
`include "ccpu_consts.vh"
module ccpu_top (
	input wire CLK,
	input wire RST_N,
	input wire [7:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [7:0] RDATA,
	input wire PIN_IN,
	output wire PIN_OUT,
	output wire PIN_OE,
	input wire PORT_LATCH,
	output wire PORT_READ,
	input wire ADC_ENABLED,
	output wire ADC_START,
	input wire ADC_DONE,
	output wire IRQ
);

	// software-visible registers; bits that read as zero are masked on write, except in sense_q, which stores all eight
	reg [7:0] ctl_q;
	reg [7:0] cmp_lo_q;
	reg [7:0] cmp_hi_q;
	reg [7:0] t1_lo_q;
	reg [7:0] t1_hi_q;
	reg [7:0] t1ctl_q;
	reg [7:0] t2ctl_q;
	reg [7:0] period_q;
	reg [7:0] flags_q;
	reg [7:0] enables_q;
	reg [7:0] interrupt_control_q;
	reg [7:0] dir_q;
	reg [7:0] sense_q;

	// unit output latch, kept apart from the port data latch
	reg out_q;
	reg pin_q;
	reg cap_pin_q;
	reg [7:0] cap_lo_q;
	reg [7:0] cap_hi_q;
	reg rd_q;
	reg [7:0] rd_addr_q;
	reg spev_q;

	// mode, timer1 and compare nets
	wire [3:0] mode;
	wire unit_off;
	wire is_cap;
	wire is_cmp;
	wire is_pwm;
	wire [15:0] t1_count;
	wire [15:0] t1_next;
	wire t1_run;
	wire t1_ovf;
	wire cmp_hit;
	wire spev;
	wire cap_src;
	reg cap_evt;

	// pwm time base nets
	wire [7:0] t2_val;
	wire [7:0] shadow;
	wire t2_match;
	wire period_tick;
	wire pwm_set;
	wire pwm_clr;
	wire wr_ctl;

	// write decode, shared by every process that takes a software write
	function hit;
		input [7:0] a;
		input [7:0] target;
		input strobe;
		begin
			hit = strobe && (a == target);
		end
	endfunction

	// mode decode [RQ20]
	assign mode = ctl_q[3:0];
	assign unit_off = (mode == `CCPU_MODE_OFF);
	assign is_cap = (mode[3:2] == 2'b01);
	assign is_cmp = (mode[3:2] == 2'b10);
	assign is_pwm = (mode[3:2] == 2'b11);
	assign wr_ctl = hit(ADDR, `CCPU_ADDR_CCPCTL, WR);

	// timer1: counts every clock while enabled; overflow flag from wrap only
	assign t1_count = {t1_hi_q, t1_lo_q};
	assign t1_run = t1ctl_q[`CCPU_BIT_T1ON];
	assign t1_next = t1_count + 16'h0001;
	assign t1_ovf = t1_run && (t1_count == 16'hffff);

	// compare equality against timer1 [RQ1] [RQ6]
	assign cmp_hit = is_cmp && ({cmp_hi_q, cmp_lo_q} == t1_count);
	assign spev = cmp_hit && (mode == `CCPU_MODE_SPEV); // [RQ8] [RQ23]
	assign ADC_START = spev_q; // [RQ9]

	// capture source: pin as input, readback of own drive as output [RQ22]
	assign cap_src = dir_q[`CCPU_BIT_PIN_DIR] ? PIN_IN : pin_q;
	always @* begin
		case (mode)
			4'h4: cap_evt = cap_pin_q && !cap_src;
			4'h5: cap_evt = !cap_pin_q && cap_src;
			4'h6: cap_evt = !cap_pin_q && cap_src;
			4'h7: cap_evt = !cap_pin_q && cap_src;
			default: cap_evt = 1'b0;
		endcase
	end

	// pwm time base; duty fields feed the double buffer only at a period end
	ccpu_pwm u_pwm (
		.clk(CLK),
		.rst_n(RST_N),
		.run(t2ctl_q[`CCPU_BIT_T2ON]),
		.presc_sel(t2ctl_q[1:0]),
		.period(period_q),
		.duty_new({cmp_lo_q, ctl_q[5:4]}), // [RQ14]
		.t2_wr(hit(ADDR, `CCPU_ADDR_T2, WR)),
		.t2_wdata(WDATA),
		.t2_q(t2_val),
		.shadow_q(shadow),
		.t2_match(t2_match),
		.period_tick(period_tick),
		.set_out(pwm_set),
		.clr_out(pwm_clr)
	);

	// pin: driven by the unit when active and direction clear [RQ4]
	assign PIN_OE = !dir_q[`CCPU_BIT_PIN_DIR];
	assign PIN_OUT = unit_off ? PORT_LATCH : out_q;
	// port bit view while unit active [RQ21]
	assign PORT_READ = unit_off ? PIN_IN : (dir_q[`CCPU_BIT_PIN_DIR] ? 1'b0 : PORT_LATCH);
	assign IRQ = interrupt_control_q[7] && interrupt_control_q[6] && |(flags_q & enables_q); // [RQ7]

	// unit output latch
	always @(posedge CLK) begin
		if (!RST_N) begin
			out_q <= 1'b0;
		end else if (wr_ctl && WDATA == `CCPU_RST_ZERO) begin
			out_q <= 1'b0; // [RQ5]
		end else if (cmp_hit && mode == `CCPU_MODE_SET) begin
			out_q <= 1'b1; // [RQ2]
		end else if (cmp_hit && mode == `CCPU_MODE_CLR) begin
			out_q <= 1'b0; // [RQ2]
		end else if (is_pwm && pwm_set) begin
			out_q <= 1'b1; // [RQ11] [RQ13]
		end else if (is_pwm && pwm_clr) begin
			out_q <= 1'b0; // [RQ18]
		end
	end

	// control, compare and timer registers
	always @(posedge CLK) begin
		if (!RST_N) begin
			ctl_q <= `CCPU_RST_ZERO;
			cmp_lo_q <= `CCPU_RST_ZERO;
			cmp_hi_q <= `CCPU_RST_ZERO;
			t1ctl_q <= `CCPU_RST_ZERO;
			t2ctl_q <= `CCPU_RST_ZERO;
			period_q <= `CCPU_RST_PERIOD;
			t1_lo_q <= `CCPU_RST_ZERO;
			t1_hi_q <= `CCPU_RST_ZERO;
			dir_q <= `CCPU_RST_DIR;
			sense_q <= `CCPU_RST_ZERO;
			interrupt_control_q <= `CCPU_RST_ZERO;
			enables_q <= `CCPU_RST_ZERO;
		end else begin
			// control bits 7:6 are unused and always read as zero
			if (wr_ctl)
				ctl_q <= {2'b00, WDATA[5:0]};
			if (hit(ADDR, `CCPU_ADDR_CMP_LO, WR))
				cmp_lo_q <= WDATA; // [RQ16]
			if (hit(ADDR, `CCPU_ADDR_CMP_HI, WR) && !is_pwm)
				cmp_hi_q <= WDATA; // [RQ16]
			else if (is_cap && cap_evt)
				cmp_hi_q <= t1_hi_q;
			if (is_cap && cap_evt)
				cmp_lo_q <= t1_lo_q;
			if (hit(ADDR, `CCPU_ADDR_T1CTL, WR))
				t1ctl_q <= {2'b00, WDATA[5:0]};
			if (hit(ADDR, `CCPU_ADDR_T2CTL, WR))
				t2ctl_q <= {5'h00, WDATA[2:0]};
			if (hit(ADDR, `CCPU_ADDR_PERIOD, WR))
				period_q <= WDATA;
			if (hit(ADDR, `CCPU_ADDR_PIN_DIR, WR))
				dir_q <= WDATA;
			if (hit(ADDR, `CCPU_ADDR_PIN_SENSE, WR))
				sense_q <= WDATA;
			if (hit(ADDR, `CCPU_ADDR_INTERRUPT_CONTROL, WR))
				interrupt_control_q <= WDATA;
			if (hit(ADDR, `CCPU_ADDR_PENABLE, WR))
				enables_q <= {1'b0, WDATA[6], 3'b000, WDATA[2:0]};
			// timer1 count: software write, special event reset, or increment
			if (hit(ADDR, `CCPU_ADDR_T1_LO, WR))
				t1_lo_q <= WDATA;
			else if (spev)
				t1_lo_q <= 8'h00; // [RQ8]
			else if (t1_run)
				t1_lo_q <= t1_next[7:0];
			if (hit(ADDR, `CCPU_ADDR_T1_HI, WR))
				t1_hi_q <= WDATA;
			else if (spev)
				t1_hi_q <= 8'h00; // [RQ8]
			else if (t1_run)
				t1_hi_q <= t1_next[15:8];
		end
	end

	// sticky flags: hardware set wins over software clear
	always @(posedge CLK) begin
		if (!RST_N) begin
			flags_q <= `CCPU_RST_ZERO;
		end else begin
			// a software write replaces the flags; the hardware sets below win
			if (hit(ADDR, `CCPU_ADDR_PFLAGS, WR))
				flags_q <= {1'b0, WDATA[6], 3'b000, WDATA[2:0]} | flags_q & 8'h00;
			if (cmp_hit || (is_cap && cap_evt))
				flags_q[`CCPU_BIT_CCPIF] <= 1'b1; // [RQ3] [RQ7]
			if (t1_ovf && !spev)
				flags_q[`CCPU_BIT_T1IF] <= 1'b1; // [RQ10]
			if (period_tick)
				flags_q[`CCPU_BIT_T2IF] <= 1'b1;
			if (ADC_DONE)
				flags_q[`CCPU_BIT_ADIF] <= 1'b1;
		end
	end

	// pin readback, edge history and special event pulse
	always @(posedge CLK) begin
		if (!RST_N) begin
			pin_q <= 1'b0;
			cap_pin_q <= 1'b0;
			spev_q <= 1'b0;
			cap_lo_q <= 8'h00;
			cap_hi_q <= 8'h00;
		end else begin
			// readback follows the driven level as output, the pin level as input
			pin_q <= PIN_OE ? PIN_OUT : PIN_IN; // [RQ22]
			cap_pin_q <= cap_src;
			spev_q <= spev && ADC_ENABLED; // [RQ9]
			cap_lo_q <= shadow;
			cap_hi_q <= t2_val;
		end
	end

	// read data one cycle after the read strobe, zero otherwise
	always @(posedge CLK) begin
		if (!RST_N) begin
			rd_q <= 1'b0;
			rd_addr_q <= 8'h00;
		end else begin
			rd_q <= RD;
			rd_addr_q <= ADDR;
		end
	end

	// read mux: registered strobe and address select one register for one cycle
	always @* begin
		RDATA = 8'h00;
		if (rd_q) begin
			case (rd_addr_q)
				`CCPU_ADDR_PIN_SENSE: RDATA = {5'h00, pin_q, 1'b0, sense_q[0]};
				`CCPU_ADDR_INTERRUPT_CONTROL: RDATA = interrupt_control_q;
				`CCPU_ADDR_PFLAGS: RDATA = flags_q;
				`CCPU_ADDR_T1_LO: RDATA = t1_lo_q;
				`CCPU_ADDR_T1_HI: RDATA = t1_hi_q;
				`CCPU_ADDR_T1CTL: RDATA = t1ctl_q;
				`CCPU_ADDR_T2: RDATA = cap_hi_q;
				`CCPU_ADDR_T2CTL: RDATA = t2ctl_q;
				`CCPU_ADDR_CMP_LO: RDATA = cmp_lo_q;
				`CCPU_ADDR_CMP_HI: RDATA = is_pwm ? cap_lo_q : cmp_hi_q; // [RQ16]
				`CCPU_ADDR_CCPCTL: RDATA = ctl_q;
				`CCPU_ADDR_PIN_DIR: RDATA = dir_q;
				`CCPU_ADDR_PERIOD: RDATA = period_q;
				`CCPU_ADDR_PENABLE: RDATA = enables_q;
				default: RDATA = 8'h00;
			endcase
		end
	end
endmodule // ccpu_top

// *** ccpu_consts.vh ***
// register offsets, field positions, mode codes and reset values of the capture/compare/pwm unit
`ifndef CCPU_CONSTS_VH
`define CCPU_CONSTS_VH
`define CCPU_ADDR_PIN_SENSE 8'h07
`define CCPU_ADDR_INTERRUPT_CONTROL 8'h0b
`define CCPU_ADDR_PFLAGS 8'h0c
`define CCPU_ADDR_T1_LO 8'h0e
`define CCPU_ADDR_T1_HI 8'h0f
`define CCPU_ADDR_T1CTL 8'h10
`define CCPU_ADDR_T2 8'h11
`define CCPU_ADDR_T2CTL 8'h12
`define CCPU_ADDR_CMP_LO 8'h15
`define CCPU_ADDR_CMP_HI 8'h16
`define CCPU_ADDR_CCPCTL 8'h17
`define CCPU_ADDR_PIN_DIR 8'h87
`define CCPU_ADDR_PERIOD 8'h92
`define CCPU_ADDR_PENABLE 8'h8c
`define CCPU_BIT_T1IF 0
`define CCPU_BIT_T2IF 1
`define CCPU_BIT_CCPIF 2
`define CCPU_BIT_ADIF 6
`define CCPU_BIT_PIN_DIR 2
`define CCPU_BIT_PIN_SENSE 2
`define CCPU_BIT_T1ON 0
`define CCPU_BIT_T2ON 2
`define CCPU_MODE_OFF 4'h0
`define CCPU_MODE_SET 4'h8
`define CCPU_MODE_CLR 4'h9
`define CCPU_MODE_SWI 4'ha
`define CCPU_MODE_SPEV 4'hb
`define CCPU_RST_ZERO 8'h00
`define CCPU_RST_DIR 8'hff
`define CCPU_RST_PERIOD 8'hff
`endif

// *** ccpu_pwm.v ***
// pwm time base: timer2 with prescaler, period match, double-buffered duty and set/clear strobes for the output latch
`timescale 1ns/10ps
module ccpu_pwm (
	input wire clk,
	input wire rst_n,
	input wire run,
	input wire [1:0] presc_sel,
	input wire [7:0] period,
	input wire [9:0] duty_new,
	input wire t2_wr,
	input wire [7:0] t2_wdata,
	output reg [7:0] t2_q,
	output reg [7:0] shadow_q,
	output wire t2_match,
	output wire period_tick,
	output wire set_out,
	output wire clr_out
);
	reg [5:0] pre_q;
	reg [1:0] lo_q;
	wire [5:0] pre_max;
	wire inc;
	wire [5:0] pre_nx;
	wire [7:0] t2_nx;
	wire [1:0] sub_nx;
	wire [9:0] fine_nx;
	// prescale 1, 4 or 16 instruction cycles; each instruction cycle has 4 clock phases
	assign pre_max = (presc_sel == 2'd0) ? 6'd3 : (presc_sel == 2'd1) ? 6'd15 : 6'd63;
	assign inc = run && (pre_q == pre_max);
	assign t2_match = (t2_q == period);
	assign period_tick = inc && t2_match; // [RQ12] [RQ13]
	// next-cycle count values, so that the registered pin clears exactly on the duty edge
	assign pre_nx = inc ? 6'h00 : pre_q + 6'h01;
	assign t2_nx = inc ? (t2_match ? 8'h00 : t2_q + 8'h01) : t2_q;
	// fine count: timer2 extended by the two prescaler bits just below one timer2 step
	assign sub_nx = (presc_sel == 2'd0) ? pre_nx[1:0] :
		(presc_sel == 2'd1) ? pre_nx[3:2] : pre_nx[5:4]; // [RQ18]
	assign fine_nx = {t2_nx, sub_nx}; // [RQ18]
	assign set_out = period_tick && (duty_new != 10'h000); // [RQ13]
	// clear on duty match; never reached if duty exceeds period [RQ19]
	assign clr_out = run && ({shadow_q, lo_q} == fine_nx) && !period_tick; // [RQ15] [RQ18]
	// prescaler, timer2 and duty double buffer
	always @(posedge clk) begin
		if (!rst_n) begin
			pre_q <= 6'h00;
			t2_q <= 8'h00;
			shadow_q <= 8'h00;
			lo_q <= 2'h0;
		end else begin
			if (t2_wr) begin
				t2_q <= t2_wdata;
				pre_q <= 6'h00;
			end else if (run) begin
				pre_q <= pre_nx;
				if (inc)
					t2_q <= t2_match ? 8'h00 : t2_q + 8'h01; // [RQ13]
			end
			if (period_tick) begin
				shadow_q <= duty_new[9:2]; // [RQ16] [RQ17]
				lo_q <= duty_new[1:0]; // [RQ17]
			end
		end
	end
endmodule // ccpu_pwm

// *** ccpu_pin_model.sv ***
// external circuit on the shared pin, driving it whenever the unit releases it
`timescale 1ns/10ps
module ccpu_pin_model (
	input wire oe,
	input wire drv,
	input wire ext,
	output wire level
);
	// resolved pin level: unit drive while its enable is set, else the outside level
	assign level = oe ? drv : ext;
endmodule // ccpu_pin_model

// *** ccpu_asserts.sv ***
// port assertions for the capture/compare/pwm unit
`timescale 1ns/10ps
module ccpu_chk (
	input wire CLK,
	input wire RST_N,
	input wire [7:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR,
	input wire RD,
	input wire [7:0] RDATA,
	input wire PIN_IN,
	input wire PIN_OUT,
	input wire PIN_OE,
	input wire PORT_LATCH,
	input wire PORT_READ,
	input wire ADC_ENABLED,
	input wire ADC_START,
	input wire ADC_DONE,
	input wire IRQ
);
	logic [5:0] ctl_q;
	logic dir_q;
	logic [1:0] ic_q;
	logic pe_q;
	wire [3:0] mode = ctl_q[3:0];
	// shadow of the software-written control fields
	always @(posedge CLK) begin
		if (!RST_N) begin
			ctl_q <= 6'h00;
			dir_q <= 1'h1;
			ic_q <= 2'h0;
			pe_q <= 1'h0;
		end else if (WR) begin
			case (ADDR)
				8'h17: ctl_q <= WDATA[5:0];
				8'h87: dir_q <= WDATA[2];
				8'h0b: ic_q <= WDATA[7:6];
				8'h8c: pe_q <= |WDATA;
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_oe; PIN_OE == !dir_q; endproperty
	property p_off; mode == 4'h0 |-> PIN_OUT == PORT_LATCH && PORT_READ == PIN_IN; endproperty
	property p_port; mode != 4'h0 |-> PORT_READ == (!dir_q && PORT_LATCH); endproperty
	property p_ctl; $past(RD && ADDR == 8'h17) |-> RDATA == {2'h0, ctl_q}; endproperty
	property p_adc; ADC_START |-> $past(mode) == 4'hb && $past(ADC_ENABLED); endproperty
	property p_irq; IRQ |-> ic_q == 2'h3 && pe_q; endproperty
	property p_clr; mode == 4'h9 && $past(mode) == 4'h9 |-> !$rose(PIN_OUT); endproperty
	property p_swi; mode == 4'ha && $past(mode) == 4'ha |-> $stable(PIN_OUT); endproperty
	a_oe: assert property (p_oe) else $error("pin enable wrong");
	a_off: assert property (p_off) else $error("off mode pin wrong");
	a_port: assert property (p_port) else $error("port read wrong");
	a_ctl: assert property (p_ctl) else $error("control read wrong");
	a_adc: assert property (p_adc) else $error("stray conversion start");
	a_irq: assert property (p_irq) else $error("interrupt not gated");
	a_clr: assert property (p_clr) else $error("pin rose in clear mode");
	a_swi: assert property (p_swi) else $error("pin moved in soft mode");
	c_adc: cover property (ADC_START);
	c_irq: cover property (IRQ);
	c_pwm: cover property (mode[3:2] == 2'h3 && $rose(PIN_OUT));
endmodule // ccpu_chk
bind ccpu_top ccpu_chk u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
	.PORT_LATCH(PORT_LATCH), .PORT_READ(PORT_READ), .ADC_ENABLED(ADC_ENABLED),
	.ADC_START(ADC_START), .ADC_DONE(ADC_DONE), .IRQ(IRQ));

// *** tb.sv ***
// self-checking bench for the capture/compare/pwm unit
`timescale 1ns/10ps
module tb;
	logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, latch = 1'h0, adc_en = 1'h0;
	logic ext = 1'h1, pin, pin_out, pin_oe, adc_start, irq;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	int errors = 0, cmp_count = 0, cyc = 0, n;
	// 250 mhz clock
	always #2 clk = ~clk;
	ccpu_top dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .PIN_IN(pin), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PORT_LATCH(latch),
		.PORT_READ(), .ADC_ENABLED(adc_en), .ADC_START(adc_start), .ADC_DONE(1'h0), .IRQ(irq));
	ccpu_pin_model pm (.oe(pin_oe), .drv(pin_out), .ext(ext), .level(pin));
	// cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			errors++;
			final_report;
		end
	end
	task automatic final_report;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask
	// one-cycle write; one-cycle read whose data is compared in the next cycle
	task automatic w(input logic [7:0] a, d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic r(input logic [7:0] a, exp);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk(rdata, exp);
	endtask
	task automatic wait_pin(input logic v);
		repeat (600) begin
			@(posedge clk);
			#1 if (pin_out === v) break;
		end
	endtask
	task automatic t_reset;
		r(8'h17, 8'h00);
		r(8'h0c, 8'h00);
		r(8'h87, 8'hff);
		r(8'h40, 8'h00);
	endtask
	// stopped timer stepped onto the compare value: pin and flag one cycle later
	task automatic hit(input logic [3:0] m, input logic [7:0] pe, ae);
		w(8'h0e, 8'h00);
		w(8'h17, {4'h0, m});
		w(8'h0c, 8'h00);
		w(8'h0e, 8'h34);
		@(posedge clk);
		#1 chk(8'(pin_out), pe);
		chk(8'(adc_start), ae);
		r(8'h0c, 8'h04);
	endtask
	task automatic t_compare;
		w(8'h87, 8'hfb);
		w(8'h16, 8'h12);
		w(8'h15, 8'h34);
		w(8'h0f, 8'h12);
		hit(4'h8, 8'h01, 8'h00);
		hit(4'h9, 8'h00, 8'h00);
		hit(4'h8, 8'h01, 8'h00);
		hit(4'ha, 8'h01, 8'h00);
		@(posedge clk) latch <= 1'h1;
		w(8'h17, 8'h00);
		#1 chk(8'(pin_out), 8'h01);
		w(8'h17, 8'h0a);
		#1 chk(8'(pin_out), 8'h00);
		@(posedge clk) adc_en <= 1'h1;
		hit(4'hb, 8'h00, 8'h01);
		r(8'h0e, 8'h00);
		w(8'h0b, 8'hc0);
		w(8'h8c, 8'h04);
		#1 chk(8'(irq), 8'h01);
		w(8'h8c, 8'h00);
		#1 chk(8'(irq), 8'h00);
	endtask
	// running timer in special event mode: compare value sets the period
	task automatic t_timer;
		w(8'h16, 8'h00);
		w(8'h15, 8'h10);
		w(8'h0c, 8'h00);
		w(8'h10, 8'h01);
		repeat (40) begin
			@(posedge clk);
			#1 if (adc_start) break;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (!adc_start && n < 40);
		chk(8'(n), 8'h11);
		r(8'h0c, 8'h04);
		w(8'h10, 8'h00);
	endtask
	// falling edge from the outside circuit captures the timer
	task automatic t_capture;
		w(8'h87, 8'hff);
		w(8'h0f, 8'h56);
		w(8'h0e, 8'h78);
		w(8'h17, 8'h04);
		w(8'h0c, 8'h00);
		@(posedge clk) ext <= 1'h0;
		tick(3);
		r(8'h15, 8'h78);
		r(8'h16, 8'h56);
		r(8'h0c, 8'h04);
		w(8'h87, 8'hfb);
	endtask
	// high clocks per period, averaged over four whole periods
	task automatic t_pwm(input logic [7:0] t2c, input logic [9:0] duty, input int per, hi);
		w(8'h92, 8'h03);
		w(8'h15, duty[9:2]);
		w(8'h17, {2'h0, duty[1:0], 4'hc});
		w(8'h12, t2c);
		tick(2 * per);
		n = 0;
		repeat (4 * per) begin
			@(posedge clk);
			#1 n += pin_out;
		end
		chk(8'(n / 4), 8'(hi));
	endtask
	// duty written mid-period stays out of the shadow until the period ends
	task automatic t_shadow;
		wait_pin(1'h0);
		wait_pin(1'h1);
		w(8'h15, 8'h20);
		r(8'h16, 8'h01);
		w(8'h16, 8'h55);
		tick(600);
		r(8'h16, 8'h20);
	endtask
	// reset, then the scenarios in turn
	initial begin
		tick(2);
		rst_n <= 1'h1;
		t_reset;
		t_compare;
		t_timer;
		t_capture;
		t_pwm(8'h04, 10'h006, 16, 6);
		t_pwm(8'h04, 10'h009, 16, 9);
		t_pwm(8'h04, 10'h000, 16, 0);
		t_pwm(8'h04, 10'h064, 16, 16);
		t_pwm(8'h05, 10'h006, 64, 24);
		t_pwm(8'h06, 10'h006, 256, 96);
		t_shadow;
		final_report;
	end
endmodule // tb
